// ### tmrb_timer2.sv
// Behaviour
// - overflow sets the overflow flag
// - no overflow flag in baud mode
// - flags cleared only by software
// - trigger edge action sets external flag
// - bit 5 selects receive clock source
// - bit 4 selects transmit clock source
// - trigger edges act when enabled, not with bit 5 or 4 set
// - trigger disabled means pin ignored
// - count only while run bit set
// - bit 1 selects pin or core clock
// - capture mode captures on trigger edge
// - reload mode reloads on overflow, edge
// - baud mode always reloads on overflow
// - count and reload as byte registers
// - all registers zero after reset, pin synchronisers high
// - timer zero and one data bytes
// - reload loads reload/capture pair
// - capture copies count into pair
// - external flag still usable in baud
`timescale 1ns/10ps
module tmrb_timer2
    import tmrb_pkg::*;
(
    input  wire logic       clk_sys,              // Core clock, 25 MHz
    input  wire logic       rst_n,                // Synchronous reset, active low
    input  wire logic       sfr_wr,               // Register write strobe
    input  wire logic       sfr_rd,               // Register read strobe
    input  wire logic [7:0] sfr_addr,             // Register address
    input  wire logic [7:0] sfr_wdata,            // Register write data
    input  wire logic       external_count_pin,   // Counter input pin
    input  wire logic       external_trigger_pin, // Capture/reload trigger pin
    input  wire logic       tmr1_overflow,        // Timer 1 overflow pulse
    output logic [7:0]      sfr_rdata_q,          // Registered read data
    output logic            sfr_rvalid_q,         // Read data valid pulse
    output logic            rx_baud_tick_q,       // Receive baud clock pulse
    output logic            tx_baud_tick_q,       // Transmit baud clock pulse
    output logic            ovf_irq_q,            // Overflow flag level
    output logic            ext_irq_q             // External flag level
);

    // ************************************************************
    // Declarations
    // ************************************************************
    tmrb_sfr_req_type req;
    tmrb_ctrl_type    ctrl_q;
    tmrb_mode_type    mode;
    logic [15:0]      count_q;
    logic [15:0]      count_d;
    logic [15:0]      rc_q;
    logic             count_fall_p;
    logic             trig_fall_p;
    logic             tick;
    logic             at_max;
    logic             overflow;
    logic             trig_act;
    logic             ext_set;
    logic             do_capture;
    logic             do_reload;
    logic             wr_ctrl;
    logic             wr_cnt_lo;
    logic             wr_cnt_hi;
    logic             wr_rc_lo;
    logic             wr_rc_hi;
    logic [7:0]       t0_lo;
    logic [7:0]       t0_hi;
    logic [7:0]       t1_lo;
    logic [7:0]       t1_hi;
    logic [7:0]       rd_mux;

    assign req = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};

    function automatic logic hit(input tmrb_sfr_req_type r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    assign wr_ctrl   = hit(req, TMRB_ADDR_CONTROL);
    assign wr_cnt_lo = hit(req, TMRB_ADDR_CNT_LOW);
    assign wr_cnt_hi = hit(req, TMRB_ADDR_CNT_HIGH);
    assign wr_rc_lo  = hit(req, TMRB_ADDR_RC_LOW);
    assign wr_rc_hi  = hit(req, TMRB_ADDR_RC_HIGH);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    tmrb_pin_sync u_count_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (external_count_pin),
        .fall_p  (count_fall_p)
    );

    tmrb_pin_sync u_trig_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (external_trigger_pin),
        .fall_p  (trig_fall_p)
    );

    // ************************************************************
    // Timer 0 and Timer 1 data bytes
    // ************************************************************
    tmrb_sfr_byte u_t0_lo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (hit(req, TMRB_ADDR_T0_LOW)),
        .wdata   (req.wdata),
        .value_q (t0_lo)
    );

    tmrb_sfr_byte u_t0_hi (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (hit(req, TMRB_ADDR_T0_HIGH)),
        .wdata   (req.wdata),
        .value_q (t0_hi)
    );

    tmrb_sfr_byte u_t1_lo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (hit(req, TMRB_ADDR_T1_LOW)),
        .wdata   (req.wdata),
        .value_q (t1_lo)
    );

    tmrb_sfr_byte u_t1_hi (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (hit(req, TMRB_ADDR_T1_HIGH)),
        .wdata   (req.wdata),
        .value_q (t1_hi)
    );

    // ************************************************************
    // Mode and event decode
    // ************************************************************
    // run bit gates mode
    assign mode = tmrb_decode_mode(ctrl_q);

    assign tick = (mode != TMRB_MODE_OFF) &&
                  (ctrl_q.counter_mode_select ? count_fall_p : 1'b1);

    assign at_max   = (count_q == 16'hFFFF);
    assign overflow = tick && at_max;

    // flag source in baud
    // The pin stays an interrupt source in baud mode, with no capture or reload
    assign ext_set = trig_fall_p && ctrl_q.external_trigger_enable;

    // trigger only with both baud selects clear
    // Trigger edges are honoured while stopped too, only not while bit 5 or bit 4 is set
    assign trig_act = ext_set &&
                      !ctrl_q.rx_baud_source_select && !ctrl_q.tx_baud_source_select;

    assign do_capture = trig_act && ctrl_q.capture_reload_select;

    assign do_reload = (overflow && (mode != TMRB_MODE_CAPTURE)) ||
                       (trig_act && !ctrl_q.capture_reload_select);

    // ************************************************************
    // Timer 2 count
    // ************************************************************
    always_comb begin
        count_d = count_q;
        if (do_reload) begin
            count_d = rc_q;
        end else if (tick) begin
            count_d = count_q + 16'h0001;
        end
    end

    // count byte registers
    // Software writes win over the hardware increment in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_q <= TMRB_RST_WORD;
        end else begin
            count_q <= count_d;
            if (wr_cnt_lo) begin
                count_q[7:0] <= req.wdata;
            end
            if (wr_cnt_hi) begin
                count_q[15:8] <= req.wdata;
            end
        end
    end

    // capture copies count
    // Capture beats a software write to the pair in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rc_q <= TMRB_RST_WORD;
        end else if (do_capture) begin
            rc_q <= count_q;
        end else begin
            if (wr_rc_lo) begin
                rc_q[7:0] <= req.wdata;
            end
            if (wr_rc_hi) begin
                rc_q[15:8] <= req.wdata;
            end
        end
    end

    // ************************************************************
    // Control register and flags
    // ************************************************************
    // zero after reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= tmrb_ctrl_type'(TMRB_RST_BYTE);
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= tmrb_ctrl_type'(req.wdata);
            end
            if (overflow && (mode != TMRB_MODE_BAUD)) begin
                ctrl_q.overflow_flag_b <= 1'b1;
            end
            if (ext_set) begin
                ctrl_q.external_event_flag <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Baud ticks and flag outputs
    // ************************************************************
    // receive clock source
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_baud_tick_q <= 1'b0;
            tx_baud_tick_q <= 1'b0;
            ovf_irq_q      <= 1'b0;
            ext_irq_q      <= 1'b0;
        end else begin
            rx_baud_tick_q <= ctrl_q.rx_baud_source_select ? overflow : tmr1_overflow;
            tx_baud_tick_q <= ctrl_q.tx_baud_source_select ? overflow : tmr1_overflow;
            ovf_irq_q      <= ctrl_q.overflow_flag_b;
            ext_irq_q      <= ctrl_q.external_event_flag;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        unique case (req.addr)
            TMRB_ADDR_T0_LOW:   rd_mux = t0_lo;
            TMRB_ADDR_T1_LOW:   rd_mux = t1_lo;
            TMRB_ADDR_T0_HIGH:  rd_mux = t0_hi;
            TMRB_ADDR_T1_HIGH:  rd_mux = t1_hi;
            TMRB_ADDR_CONTROL:  rd_mux = ctrl_q;
            TMRB_ADDR_RC_LOW:   rd_mux = rc_q[7:0];
            TMRB_ADDR_RC_HIGH:  rd_mux = rc_q[15:8];
            TMRB_ADDR_CNT_LOW:  rd_mux = count_q[7:0];
            TMRB_ADDR_CNT_HIGH: rd_mux = count_q[15:8];
            default:            rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sfr_rdata_q  <= 8'h00;
            sfr_rvalid_q <= 1'b0;
        end else begin
            sfr_rvalid_q <= req.rd;
            if (req.rd) begin
                sfr_rdata_q <= rd_mux;
            end
        end
    end

endmodule

// ### tmrb_pkg.sv
package tmrb_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] TMRB_ADDR_T0_LOW   = 8'h8A;
    localparam logic [7:0] TMRB_ADDR_T1_LOW   = 8'h8B;
    localparam logic [7:0] TMRB_ADDR_T0_HIGH  = 8'h8C;
    localparam logic [7:0] TMRB_ADDR_T1_HIGH  = 8'h8D;
    localparam logic [7:0] TMRB_ADDR_CONTROL  = 8'hC8;
    localparam logic [7:0] TMRB_ADDR_RC_LOW   = 8'hCA;
    localparam logic [7:0] TMRB_ADDR_RC_HIGH  = 8'hCB;
    localparam logic [7:0] TMRB_ADDR_CNT_LOW  = 8'hCC;
    localparam logic [7:0] TMRB_ADDR_CNT_HIGH = 8'hCD;

    // ************************************************************
    // Control field positions and reset values
    // ************************************************************
    localparam int TMRB_BIT_OVF   = 7;
    localparam int TMRB_BIT_EXF   = 6;
    localparam int TMRB_BIT_RXSEL = 5;
    localparam int TMRB_BIT_TXSEL = 4;
    localparam int TMRB_BIT_EXEN  = 3;
    localparam int TMRB_BIT_RUN   = 2;
    localparam int TMRB_BIT_CNT   = 1;
    localparam int TMRB_BIT_CAP   = 0;

    localparam logic [7:0]  TMRB_RST_BYTE = 8'h00;
    localparam logic [15:0] TMRB_RST_WORD = 16'h0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic overflow_flag_b;
        logic external_event_flag;
        logic rx_baud_source_select;
        logic tx_baud_source_select;
        logic external_trigger_enable;
        logic run_control_b;
        logic counter_mode_select;
        logic capture_reload_select;
    } tmrb_ctrl_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmrb_sfr_req_type;

    typedef enum logic [1:0] {
        TMRB_MODE_OFF,
        TMRB_MODE_RELOAD,
        TMRB_MODE_CAPTURE,
        TMRB_MODE_BAUD
    } tmrb_mode_type;

    function automatic tmrb_mode_type tmrb_decode_mode(input tmrb_ctrl_type c);
        if (!c.run_control_b) begin
            tmrb_decode_mode = TMRB_MODE_OFF;
        end else if (c.rx_baud_source_select || c.tx_baud_source_select) begin
            tmrb_decode_mode = TMRB_MODE_BAUD;
        end else if (c.capture_reload_select) begin
            tmrb_decode_mode = TMRB_MODE_CAPTURE;
        end else begin
            tmrb_decode_mode = TMRB_MODE_RELOAD;
        end
    endfunction

endpackage

// ### tmrb_pin_sync.sv
`timescale 1ns/10ps
module tmrb_pin_sync
    import tmrb_pkg::*;
(
    input  wire logic clk_sys,   // Core clock
    input  wire logic rst_n,     // Synchronous reset, active low
    input  wire logic pin_in,    // Asynchronous pin
    output logic      fall_p     // One-cycle pulse on a falling edge
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ************************************************************
    // Two-stage synchroniser and edge detect
    // ************************************************************
    // sync and edge
    // Reset to high, so a pin held low through reset gives one fall pulse after reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
            fall_p <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            fall_p <= prev_q & ~sync_q;
        end
    end

endmodule

// ### tmrb_sfr_byte.sv
`timescale 1ns/10ps
module tmrb_sfr_byte
    import tmrb_pkg::*;
(
    input  wire logic       clk_sys,  // Core clock
    input  wire logic       rst_n,    // Synchronous reset, active low
    input  wire logic       wr_en,    // Software write strobe
    input  wire logic [7:0] wdata,    // Write data
    output logic [7:0]      value_q   // Stored byte
);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            value_q <= TMRB_RST_BYTE;
        end else if (wr_en) begin
            value_q <= wdata;
        end
    end

endmodule

// ### tmrb_timer2_sva.sv
`timescale 1ns/10ps
module tmrb_timer2_sva
    import tmrb_pkg::*;
(
    input wire logic       clk_sys,              // Core clock
    input wire logic       rst_n,                // Reset, active low
    input wire logic       sfr_wr,               // Write strobe
    input wire logic       sfr_rd,               // Read strobe
    input wire logic [7:0] sfr_addr,             // Address
    input wire logic [7:0] sfr_wdata,            // Write data
    input wire logic       external_count_pin,   // Count pin
    input wire logic       external_trigger_pin, // Trigger pin
    input wire logic       tmr1_overflow,        // Timer 1 overflow
    input wire logic [7:0] sfr_rdata_q,          // Read data
    input wire logic       sfr_rvalid_q,         // Read valid
    input wire logic       rx_baud_tick_q,       // Receive tick
    input wire logic       tx_baud_tick_q,       // Transmit tick
    input wire logic       ovf_irq_q,            // Overflow flag
    input wire logic       ext_irq_q             // External flag
);
    logic rxsel_q;
    logic txsel_q;
    logic exen_q;
    logic wr_ctrl;

    // **********************************
    // Shadows of software-only bits
    // **********************************
    assign wr_ctrl = sfr_wr && (sfr_addr == TMRB_ADDR_CONTROL);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxsel_q <= 1'b0;
            txsel_q <= 1'b0;
            exen_q  <= 1'b0;
        end else if (wr_ctrl) begin
            rxsel_q <= sfr_wdata[TMRB_BIT_RXSEL];
            txsel_q <= sfr_wdata[TMRB_BIT_TXSEL];
            exen_q  <= sfr_wdata[TMRB_BIT_EXEN];
        end
    end

    // **********************************
    // Properties
    // **********************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (sfr_rd |=> sfr_rvalid_q)
        else $error("read strobe gave no valid pulse");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !ovf_irq_q && !ext_irq_q
        && !rx_baud_tick_q && !tx_baud_tick_q) else $error("output active after reset");
    a_rx_from_t1: assert property (!rxsel_q |=> rx_baud_tick_q == $past(tmr1_overflow))
        else $error("receive tick not from timer 1");
    a_tx_from_t1: assert property (!txsel_q |=> tx_baud_tick_q == $past(tmr1_overflow))
        else $error("transmit tick not from timer 1");
    a_no_ovf_baud: assert property ($rose(ovf_irq_q) && $past(rxsel_q || txsel_q, 2)
        |-> $past(wr_ctrl && sfr_wdata[7], 2)) else $error("overflow flag set in baud mode");
    a_ovf_sticky: assert property ($fell(ovf_irq_q) |-> $past(wr_ctrl && !sfr_wdata[7], 2))
        else $error("overflow flag cleared by hardware");
    a_ext_sticky: assert property ($fell(ext_irq_q) |-> $past(wr_ctrl && !sfr_wdata[6], 2))
        else $error("external flag cleared by hardware");
    a_ext_gated: assert property ($rose(ext_irq_q) && !$past(exen_q, 2)
        |-> $past(wr_ctrl && sfr_wdata[6], 2)) else $error("external flag set while disabled");
    a_ext_sets: assert property ($fell(external_trigger_pin) && exen_q
        |-> ##[3:10] ext_irq_q) else $error("trigger edge did not set flag");
endmodule

bind tmrb_timer2 tmrb_timer2_sva u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .external_count_pin(external_count_pin),
    .external_trigger_pin(external_trigger_pin), .tmr1_overflow(tmr1_overflow),
    .sfr_rdata_q(sfr_rdata_q), .sfr_rvalid_q(sfr_rvalid_q), .rx_baud_tick_q(rx_baud_tick_q),
    .tx_baud_tick_q(tx_baud_tick_q), .ovf_irq_q(ovf_irq_q), .ext_irq_q(ext_irq_q)
);

// ### tmrb_pin_model.sv
`timescale 1ns/10ps
module tmrb_pin_model (
    input  wire logic clk_sys,  // Core clock
    input  wire logic rst_n,    // Reset, active low
    input  wire logic trig_req, // Ask for one trigger fall
    input  wire logic cnt_req,  // Ask for one count fall
    output logic      trig_pin, // Trigger pin, idles high
    output logic      cnt_pin   // Count pin, idles high
);
    logic [2:0] trig_q;
    logic [2:0] cnt_q;

    // **********************************
    // Pin pulse shaping
    // **********************************
    // Three low cycles so a two-stage synchroniser never misses a fall
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trig_q <= 3'h0;
            cnt_q  <= 3'h0;
        end else begin
            trig_q <= trig_req ? 3'h7 : (trig_q >> 1);
            cnt_q  <= cnt_req ? 3'h7 : (cnt_q >> 1);
        end
    end

    assign trig_pin = ~trig_q[0];
    assign cnt_pin  = ~cnt_q[0];
endmodule

// ### tmrb_timer2_tb_top.sv
`timescale 1ns/10ps
module tmrb_timer2_tb_top
    import tmrb_pkg::*;
;
    logic       clk_sys       = 1'b0;
    logic       rst_n         = 1'b0;
    logic       sfr_wr        = 1'b0;
    logic       sfr_rd        = 1'b0;
    logic [7:0] sfr_addr      = 8'h00;
    logic [7:0] sfr_wdata     = 8'h00;
    logic       tmr1_overflow = 1'b0;
    logic       trig_req      = 1'b0;
    logic       cnt_req       = 1'b0;
    logic       trig_pin;
    logic       cnt_pin;
    logic [7:0] rdata;
    logic       rvalid;
    logic       rx_tick;
    logic       tx_tick;
    logic       ovf_irq;
    logic       ext_irq;
    int         fails         = 0;
    int         n_compared    = 0;
    int         n_rx          = 0;
    int         n_tx          = 0;

    always #20 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        n_rx += int'(rx_tick === 1'b1);
        n_tx += int'(tx_tick === 1'b1);
    end

    tmrb_timer2 dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .external_count_pin(cnt_pin),
        .external_trigger_pin(trig_pin), .tmr1_overflow(tmr1_overflow),
        .sfr_rdata_q(rdata), .sfr_rvalid_q(rvalid), .rx_baud_tick_q(rx_tick),
        .tx_baud_tick_q(tx_tick), .ovf_irq_q(ovf_irq), .ext_irq_q(ext_irq)
    );

    tmrb_pin_model u_pins (
        .clk_sys(clk_sys), .rst_n(rst_n), .trig_req(trig_req), .cnt_req(cnt_req),
        .trig_pin(trig_pin), .cnt_pin(cnt_pin)
    );

    // **********************************
    // Access tasks
    // **********************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask

    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        chk({7'h00, rvalid, rdata}, {8'h01, e});
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rdx(a, e[7:0]);
        rdx(a + 8'h01, e[15:8]);
    endtask

    task automatic pin(input logic trig);
        @(posedge clk_sys);
        trig_req <= trig;
        cnt_req <= ~trig;
        @(posedge clk_sys);
        trig_req <= 1'b0;
        cnt_req <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // **********************************
    // Tests
    // **********************************
    initial begin
        static logic [7:0]  regs [9] = '{TMRB_ADDR_T0_LOW, TMRB_ADDR_T1_LOW, TMRB_ADDR_T0_HIGH,
            TMRB_ADDR_T1_HIGH, TMRB_ADDR_CONTROL, TMRB_ADDR_RC_LOW, TMRB_ADDR_RC_HIGH,
            TMRB_ADDR_CNT_LOW, TMRB_ADDR_CNT_HIGH};
        static logic [7:0]  ovc [4] = '{8'h04, 8'h05, 8'h14, 8'h25};
        static logic [15:0] ovx [4] = '{16'h1236, 16'h0002, 16'h1236, 16'h1236};
        static logic [7:0]  tgc [4] = '{8'h09, 8'h08, 8'h00, 8'h28};
        static logic [15:0] tgx [4] = '{16'hABCD, 16'h1234, 16'hABCD, 16'hABCD};
        static logic [15:0] tgr [4] = '{16'hABCD, 16'h1234, 16'h1234, 16'h1234};
        int r0;
        int t0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (regs[i]) rdx(regs[i], 8'h00);
        wr(8'h8E, 8'hFF);
        rdx(8'h8E, 8'h00);
        $display("test reset done");
        foreach (regs[i]) if (i != 4) wr(regs[i], 8'(17 * i + 15));
        foreach (regs[i]) if (i != 4) rdx(regs[i], 8'(17 * i + 15));
        $display("test data bytes done");
        // Each run spans four increments from 0xFFFE, so one overflow
        foreach (ovc[i]) begin
            wr16(TMRB_ADDR_CNT_LOW, 16'hFFFE);
            wr16(TMRB_ADDR_RC_LOW, 16'h1234);
            r0 = n_rx;
            t0 = n_tx;
            wr(TMRB_ADDR_CONTROL, ovc[i]);
            repeat (2) @(posedge clk_sys);
            wr(TMRB_ADDR_CONTROL, 8'h00);
            #1;
            chk(16'(ovf_irq), 16'(ovc[i] < 8'h10));
            chk(16'(n_tx - t0), 16'(ovc[i] == 8'h14));
            chk(16'(n_rx - r0), 16'(ovc[i] == 8'h25));
            rd16(TMRB_ADDR_CNT_LOW, ovx[i]);
            rdx(TMRB_ADDR_CONTROL, 8'h00);
        end
        $display("test overflow done");
        r0 = n_rx;
        t0 = n_tx;
        @(posedge clk_sys);
        tmr1_overflow <= 1'b1;
        @(posedge clk_sys);
        tmr1_overflow <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(16'(n_rx - r0), 16'h0001);
        chk(16'(n_tx - t0), 16'h0001);
        wr16(TMRB_ADDR_CNT_LOW, 16'h0000);
        wr(TMRB_ADDR_CONTROL, 8'h06);
        repeat (3) pin(1'b0);
        wr(TMRB_ADDR_CONTROL, 8'h00);
        rd16(TMRB_ADDR_CNT_LOW, 16'h0003);
        $display("test sources done");
        foreach (tgc[i]) begin
            wr16(TMRB_ADDR_RC_LOW, 16'h1234);
            wr16(TMRB_ADDR_CNT_LOW, 16'hABCD);
            wr(TMRB_ADDR_CONTROL, tgc[i]);
            pin(1'b1);
            rd16(TMRB_ADDR_CNT_LOW, tgx[i]);
            rd16(TMRB_ADDR_RC_LOW, tgr[i]);
            rdx(TMRB_ADDR_CONTROL, tgc[i] | (tgc[i][3] ? 8'h40 : 8'h00));
            chk(16'(ext_irq), 16'(tgc[i][3]));
        end
        // Software clear of the external flag lands on the edge that sets it
        wr(TMRB_ADDR_CONTROL, 8'h08);
        @(posedge clk_sys);
        trig_req <= 1'b1;
        @(posedge clk_sys);
        trig_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        wr(TMRB_ADDR_CONTROL, 8'h08);
        rdx(TMRB_ADDR_CONTROL, 8'h48);
        $display("test trigger done");
        close_out();
    end
endmodule
